/* verilog/udr_pkg.sv */
package udr_pkg;
   // data and fifo shape
   localparam int DATA_W        = 8;
   localparam int FIFO_DEPTH    = 16;
   localparam int CNT_W         = 5;
   // receive trigger level in characters
   localparam logic [4:0] RX_TRIG_DEFAULT = 5'h04;
   // receive timeout in character-idle clock cycles
   localparam int RX_TIMEOUT_CYC = 64;
   // reset values of the mode bits
   localparam logic FIFO_EN_RST  = 1'b0;
   localparam logic DMA_MODE_RST = 1'b0;
   // idle marking level of the serial output
   localparam logic TX_IDLE      = 1'b1;
   // host strobe and gap timer loads; longer than the device sync delay
   localparam logic [2:0] STRB_CYC = 3'h4;
   localparam logic [2:0] GAP_CYC  = 3'h6;
endpackage : udr_pkg

/* verilog/udr_if.sv */
`timescale 1ns/100ps
// joins the dma controller and the uart dma signalling end
interface udr_if;
   logic       sel;          // uart selected
   logic       wr_strobe_n;  // active-low write strobe
   logic       wr_strobe;    // active-high write strobe
   logic       rd_strobe;    // read strobe, held several cycles; one read per rising edge
   logic [7:0] wr_data;      // host write data
   logic [7:0] rd_data;      // receive data to host
   logic       rx_dma_request_n;
   logic       tx_dma_request_n;
   modport dev  (input sel, wr_strobe_n, wr_strobe, rd_strobe, wr_data,
                 output rd_data, rx_dma_request_n, tx_dma_request_n);
   modport host (output sel, wr_strobe_n, wr_strobe, rd_strobe, wr_data,
                 input rd_data, rx_dma_request_n, tx_dma_request_n);
endinterface : udr_if

/* verilog/udr_buf2.sv */
`timescale 1ns/100ps
// two-entry skid buffer, valid/ready on both sides
module udr_buf2 #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // filling side
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   // draining side
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   logic [W-1:0] mem_reg [2];  // two storage words
   logic         wp_reg;       // write pointer
   logic         rp_reg;       // read pointer
   logic [1:0]   cnt_reg;      // fill count
   logic         push;
   logic         pop;

   // full stalls the filler, so no word is lost
   assign in_ready  = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data  = mem_reg[rp_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         if (push) wp_reg <= ~wp_reg;
         if (pop) rp_reg <= ~rp_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : udr_buf2

/* verilog/udr_dev.sv */
`timescale 1ns/100ps
// What this block does
// RULE1 - fifo mode: mode bit picks dma mode
// RULE2 - fifo disabled: always mode 0
// RULE3 - mode 0: one transfer per request
// RULE4 - rx mode 0: request low if any character
// RULE5 - rx mode 0: high once receive empty
// RULE6 - rx mode 1: low at trigger or timeout
// RULE7 - rx mode 1: high only when empty
// RULE8 - rx mode 1: host reads until empty
// RULE9 - tx mode 1: host writes until full
// RULE10 - reset forces serial output high
// RULE11 - write when selected and either strobe
// RULE12 - host ties unused strobe inactive
// RULE13 - tx mode 0: low when transmit empty
module udr_dev #(
   parameter int          DEPTH   = udr_pkg::FIFO_DEPTH,
   parameter logic [4:0]  RX_TRIG = udr_pkg::RX_TRIG_DEFAULT,
   parameter int          TMO_CYC = udr_pkg::RX_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // host side
   udr_if.dev              bus,
   // mode control
   input  wire logic       fifo_enable_bit,
   input  wire logic       dma_mode_select_bit,
   // received characters from the serial side
   input  wire logic       rx_char_valid,
   output      logic       rx_char_ready,
   input  wire logic [7:0] rx_char,
   // transmitted characters to the serial side
   output      logic       tx_char_valid,
   input  wire logic       tx_char_ready,
   output      logic [7:0] tx_char,
   // serial output
   output      logic       tx_serial
);
   localparam int AW = $clog2(DEPTH);

   // mode decode
   logic mode1;
   logic [4:0] cap;                      // fifo capacity, 1 in legacy mode
   assign mode1 = fifo_enable_bit & dma_mode_select_bit; // see RULE1 RULE2
   assign cap   = fifo_enable_bit ? 5'(DEPTH) : 5'h01;

   // strobe synchronisers, strobes come from off-chip
   logic [1:0] wrn_s_reg;
   logic [1:0] wrh_s_reg;
   logic [1:0] sel_s_reg;
   logic [1:0] rd_s_reg;
   logic       wr_lvl_reg;  // last write level, for edge detect
   logic       rd_lvl_reg;
   logic       wr_act;
   logic       wr_pulse;
   logic       rd_pulse;

   // two flops per pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrn_s_reg <= 2'h3;
         wrh_s_reg <= 2'h0;
         sel_s_reg <= 2'h0;
         rd_s_reg  <= 2'h0;
      end else begin
         wrn_s_reg <= {wrn_s_reg[0], bus.wr_strobe_n};
         wrh_s_reg <= {wrh_s_reg[0], bus.wr_strobe};
         sel_s_reg <= {sel_s_reg[0], bus.sel};
         rd_s_reg  <= {rd_s_reg[0], bus.rd_strobe};
      end
   end

   // either strobe while selected makes a write
   assign wr_act = sel_s_reg[1] & (~wrn_s_reg[1] | wrh_s_reg[1]); // see RULE11

   // one write per strobe, on its leading edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_lvl_reg <= 1'b0;
         rd_lvl_reg <= 1'b0;
      end else begin
         wr_lvl_reg <= wr_act;
         rd_lvl_reg <= rd_s_reg[1] & sel_s_reg[1];
      end
   end
   assign wr_pulse = wr_act & ~wr_lvl_reg;
   assign rd_pulse = rd_s_reg[1] & sel_s_reg[1] & ~rd_lvl_reg;

   // receive fifo
   logic [7:0]    rxm_reg [DEPTH];
   logic [AW-1:0] rxw_reg;
   logic [AW-1:0] rxr_reg;
   logic [4:0]    rxc_reg;
   logic          rx_push;
   logic          rx_pop;
   assign rx_char_ready = (rxc_reg < cap);
   assign rx_push = rx_char_valid & rx_char_ready;
   assign rx_pop  = rd_pulse & (rxc_reg != 5'h00);

   // receive storage
   always_ff @(posedge clk) begin
      if (rx_push) rxm_reg[rxw_reg] <= rx_char;
   end

   // receive pointers and read data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxw_reg     <= '0;
         rxr_reg     <= '0;
         rxc_reg     <= 5'h00;
         bus.rd_data <= 8'h00;
      end else begin
         if (rx_push) rxw_reg <= AW'(rxw_reg + 1'b1);
         if (rx_pop) begin
            rxr_reg     <= AW'(rxr_reg + 1'b1);
            bus.rd_data <= rxm_reg[rxr_reg];
         end
         rxc_reg <= rxc_reg + {4'h0, rx_push} - {4'h0, rx_pop};
      end
   end

   // receive timeout: characters waiting and no traffic for a while
   logic [$clog2(TMO_CYC+1)-1:0] tmo_reg;
   logic                          tmo_hit;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmo_reg <= '0;
      end else if (rx_push | rx_pop | rxc_reg == 5'h00) begin
         tmo_reg <= '0;
      end else if (!tmo_hit) begin
         tmo_reg <= tmo_reg + 1'b1;
      end
   end
   assign tmo_hit = (tmo_reg == ($clog2(TMO_CYC+1))'(TMO_CYC));

   // receive request; mode 1 holds low once raised until empty
   logic rx_req_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_req_reg <= 1'b0;
      end else if (!mode1) begin
         rx_req_reg <= (rx_char_valid && rx_char_ready) ||
                       (rxc_reg - {4'h0, rx_pop} != 5'h00); // see RULE4 RULE5
      end else if (rxc_reg + {4'h0, rx_push} - {4'h0, rx_pop} == 5'h00) begin
         rx_req_reg <= 1'b0;                                 // see RULE7
      end else if (rxc_reg >= RX_TRIG || tmo_hit) begin
         rx_req_reg <= 1'b1;                                 // see RULE6 RULE8
      end
   end
   assign bus.rx_dma_request_n = ~rx_req_reg;

   // transmit occupancy: fifo plus buffer, capped by mode capacity
   logic [4:0] txc_reg;
   logic       tx_take;     // write accepted
   logic       tx_out;      // word leaves to the serial side
   logic       txb_ready;
   logic       txb_valid;
   logic [7:0] txb_data;
   assign tx_take = wr_pulse & (txc_reg < cap); // full: write dropped
   assign tx_out  = txb_valid & tx_char_ready;

   // transmit fifo ahead of the buffer; a stalled line keeps every word
   logic [7:0]    txm_reg [DEPTH];
   logic [AW-1:0] txw_reg;      // write pointer
   logic [AW-1:0] txr_reg;      // read pointer
   logic [4:0]    txf_reg;      // words still in the fifo part
   logic          txf_any;      // fifo has a word for the buffer
   logic          txf_pop;      // buffer takes that word
   assign txf_any = (txf_reg != 5'h00);
   assign txf_pop = txf_any & txb_ready;

   // transmit storage; never overruns since occupancy never exceeds cap
   always_ff @(posedge clk) begin
      if (tx_take) txm_reg[txw_reg] <= bus.wr_data;
   end

   // transmit fifo pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txw_reg <= '0;
         txr_reg <= '0;
         txf_reg <= 5'h00;
      end else begin
         if (tx_take) txw_reg <= AW'(txw_reg + 1'b1);
         if (txf_pop) txr_reg <= AW'(txr_reg + 1'b1);
         txf_reg <= txf_reg + {4'h0, tx_take} - {4'h0, txf_pop};
      end
   end

   udr_buf2 #(.W(8)) u_txbuf (
      .clk      (clk),
      .rst_n    (rst_n),
      .in_valid (txf_any),
      .in_ready (txb_ready),
      .in_data  (txm_reg[txr_reg]),
      .out_valid(txb_valid),
      .out_ready(tx_char_ready),
      .out_data (txb_data)
   );
   assign tx_char_valid = txb_valid;
   assign tx_char       = txb_data;

   // occupancy counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txc_reg <= 5'h00;
      end else begin
         txc_reg <= txc_reg + {4'h0, tx_take} - {4'h0, tx_out};
      end
   end

   // transmit request: mode 0 only when empty, mode 1 until full
   logic tx_req_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_req_reg <= 1'b1;
      end else if (!mode1) begin
         tx_req_reg <= (txc_reg == 5'h00) && !tx_take; // see RULE13 RULE3
      end else begin
         tx_req_reg <= (txc_reg + {4'h0, tx_take} < cap);    // see RULE9
      end
   end
   assign bus.tx_dma_request_n = ~tx_req_reg;

   // serial line idles marking from reset; framing lives elsewhere
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_serial <= udr_pkg::TX_IDLE;                      // see RULE10
      end else begin
         tx_serial <= udr_pkg::TX_IDLE;
      end
   end
endmodule : udr_dev

/* verilog/udr_host.sv */
`timescale 1ns/100ps
// dma controller end: moves words on request
module udr_host #(
   parameter logic USE_LOW_STROBE = 1'b1
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // device side
   udr_if.host             bus,
   // user: words to send
   input  wire logic       send_valid,
   output      logic       send_ready,
   input  wire logic [7:0] send_data,
   // user: words received
   output      logic       recv_valid,
   output      logic [7:0] recv_data
);
   // synchronised requests
   logic [1:0] rxq_s_reg;
   logic [1:0] txq_s_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxq_s_reg <= 2'h3;
         txq_s_reg <= 2'h3;
      end else begin
         rxq_s_reg <= {rxq_s_reg[0], bus.rx_dma_request_n};
         txq_s_reg <= {txq_s_reg[0], bus.tx_dma_request_n};
      end
   end

   typedef enum logic [3:0] {
      UDR_IDLE = 4'h1,
      UDR_WR   = 4'h2,
      UDR_RD   = 4'h4,
      UDR_GAP  = 4'h8
   } udr_st_t;
   udr_st_t    st_reg;
   logic [2:0] tmr_reg;   // strobe/gap length, covers device sync
   logic       strb_reg;
   logic [7:0] wd_reg;

   assign send_ready = (st_reg == UDR_IDLE) & ~txq_s_reg[1] & rxq_s_reg[1];
   // only one strobe is used, the other sits inactive; see RULE12
   assign bus.wr_strobe_n = USE_LOW_STROBE ? ~(strb_reg && st_reg == UDR_WR)
                                           : 1'b1;
   assign bus.wr_strobe   = USE_LOW_STROBE ? 1'b0
                                           : (strb_reg && st_reg == UDR_WR);
   assign bus.rd_strobe   = strb_reg && st_reg == UDR_RD;
   assign bus.sel         = 1'b1;
   assign bus.wr_data     = wd_reg;

   // one transfer per request check; reads win over writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg     <= UDR_IDLE;
         tmr_reg    <= 3'h0;
         strb_reg   <= 1'b0;
         wd_reg     <= 8'h00;
         recv_valid <= 1'b0;
         recv_data  <= 8'h00;
      end else begin
         recv_valid <= 1'b0;
         case (st_reg)
            UDR_IDLE: begin
               if (!rxq_s_reg[1]) begin
                  st_reg   <= UDR_RD;   // see RULE8
                  strb_reg <= 1'b1;
                  tmr_reg  <= udr_pkg::STRB_CYC;
               end else if (send_valid && !txq_s_reg[1]) begin
                  st_reg   <= UDR_WR;   // see RULE9
                  wd_reg   <= send_data;
                  strb_reg <= 1'b1;
                  tmr_reg  <= udr_pkg::STRB_CYC;
               end
            end
            UDR_WR, UDR_RD: begin
               tmr_reg <= tmr_reg - 3'h1;
               if (tmr_reg == 3'h0) begin
                  strb_reg <= 1'b0;
                  st_reg   <= UDR_GAP;
                  tmr_reg  <= udr_pkg::GAP_CYC;
               end
            end
            UDR_GAP: begin
               // wait for the request to settle before looking again
               tmr_reg <= tmr_reg - 3'h1;
               if (tmr_reg == 3'h3 && bus.rd_strobe == 1'b0) begin
                  recv_data <= bus.rd_data;
               end
               if (tmr_reg == 3'h0) st_reg <= UDR_IDLE;   // see RULE3
            end
            default: st_reg <= UDR_IDLE;
         endcase
         if (st_reg == UDR_RD && tmr_reg == 3'h0) recv_valid <= 1'b1;
         if (st_reg == UDR_RD && tmr_reg == 3'h0) recv_data <= bus.rd_data;
      end
   end
endmodule : udr_host

/* dv/udr_monitor.sv */
`timescale 1ns/100ps
// watches the handshake wires between the two ends
module udr_monitor (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // interface wires
   input wire logic       sel,
   input wire logic       wr_strobe_n,
   input wire logic       wr_strobe,
   input wire logic       rd_strobe,
   input wire logic [7:0] wr_data,
   input wire logic       rx_dma_request_n,
   input wire logic       tx_dma_request_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // write phase as the device decodes it
   wire logic wr_act = sel && (!wr_strobe_n || wr_strobe);

   reset_idle_a : assert property (
      $rose(rst_n) |-> rx_dma_request_n && !tx_dma_request_n)
      else $error("requests not idle after reset");
   strobe_excl_a : assert property (
      !wr_strobe_n |-> !wr_strobe)
      else $error("both write strobes active");
   rd_hold_a : assert property (
      $rose(rd_strobe) |-> rd_strobe [*3])
      else $error("read strobe too short");
   rd_gap_a : assert property (
      $fell(rd_strobe) |-> !rd_strobe [*3])
      else $error("read strobe gap too short");
   wr_hold_a : assert property (
      $rose(wr_act) |=> (wr_act && $stable(wr_data)) [*2])
      else $error("write phase not held");
   rd_on_req_a : assert property (
      $rose(rd_strobe) |-> !$past(rx_dma_request_n))
      else $error("read without receive request");
   rx_hold_a : assert property (
      $rose(rx_dma_request_n) |-> rd_strobe || $past(rd_strobe))
      else $error("receive request dropped without read");
   wr_on_req_a : assert property (
      $rose(wr_act) |-> !$past(tx_dma_request_n))
      else $error("write without transmit request");
   tx_rise_a : assert property (
      $rose(tx_dma_request_n) |-> wr_act || $past(wr_act))
      else $error("transmit request rose without write");
endmodule : udr_monitor

/* dv/testbench.sv */
`timescale 1ns/100ps
// drives both user sides and compares words end to end
module testbench;
   logic       clk      = 1'b0;  // 40 mhz
   logic       rst_n    = 1'b0;  // async reset
   logic       fifo_en  = 1'b0;  // fifo enable bit
   logic       dma_mode = 1'b0;  // dma mode select bit
   logic       rx_v     = 1'b0;  // received char push
   logic       rx_r;
   logic [7:0] rx_d     = 8'h00;
   logic       tx_v;             // serial side pull
   logic       tx_r     = 1'b1;
   logic [7:0] tx_d;
   logic       tx_ser;
   logic       snd_v    = 1'b0;  // user words to send
   logic       snd_r;
   logic [7:0] snd_d    = 8'h00;
   logic       rcv_v;            // user words received
   logic [7:0] rcv_d;
   int         n_mismatch  = 0;
   int         checks_done = 0;
   logic [7:0] got_rx[$];        // words seen by the host user
   logic [7:0] got_tx[$];        // words seen on the serial side

   always #12.5 clk = ~clk;

   udr_if udr_if_i ();
   // short timeout keeps the idle waits brief
   udr_dev #(.TMO_CYC(40)) udr_dev_i (.clk(clk), .rst_n(rst_n),
      .bus(udr_if_i), .fifo_enable_bit(fifo_en),
      .dma_mode_select_bit(dma_mode), .rx_char_valid(rx_v),
      .rx_char_ready(rx_r), .rx_char(rx_d), .tx_char_valid(tx_v),
      .tx_char_ready(tx_r), .tx_char(tx_d), .tx_serial(tx_ser));
   udr_host udr_host_i (.clk(clk), .rst_n(rst_n), .bus(udr_if_i),
      .send_valid(snd_v), .send_ready(snd_r), .send_data(snd_d),
      .recv_valid(rcv_v), .recv_data(rcv_d));
   udr_monitor udr_monitor_i (.clk(clk), .rst_n(rst_n),
      .sel(udr_if_i.sel), .wr_strobe_n(udr_if_i.wr_strobe_n),
      .wr_strobe(udr_if_i.wr_strobe), .rd_strobe(udr_if_i.rd_strobe),
      .wr_data(udr_if_i.wr_data),
      .rx_dma_request_n(udr_if_i.rx_dma_request_n),
      .tx_dma_request_n(udr_if_i.tx_dma_request_n));

   // record every word leaving either end
   always @(posedge clk) begin
      if (rcv_v === 1'b1) got_rx.push_back(rcv_d);
      if (tx_v === 1'b1 && tx_r === 1'b1) got_tx.push_back(tx_d);
   end

   task automatic conclude();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // push one received char; ready is combinational, so hold until seen
   task automatic push_rx(input logic [7:0] d);
      int i;
      @(negedge clk);
      rx_v = 1'b1;
      rx_d = d;
      for (i = 0; i < 100 && rx_r !== 1'b1; i++) @(negedge clk);
      if (rx_r !== 1'b1) begin
         n_mismatch++;
         conclude();
      end
      @(negedge clk);
      rx_v = 1'b0;
   endtask : push_rx

   // offer one word to the host end; ok says if it was taken
   task automatic send(input logic [7:0] d, input int lim,
                       output logic ok);
      int i;
      @(negedge clk);
      snd_v = 1'b1;
      snd_d = d;
      for (i = 0; i < lim && snd_r !== 1'b1; i++) @(negedge clk);
      ok = snd_r;
      @(negedge clk);
      snd_v = 1'b0;
   endtask : send

   // bounded wait until n words collected on one side
   task automatic wait_n(input bit tx, input int n, input int lim);
      int i;
      for (i = 0; i < lim && (tx ? got_tx.size() : got_rx.size()) < n;
           i++) @(negedge clk);
      if ((tx ? got_tx.size() : got_rx.size()) < n) begin
         n_mismatch++;
         conclude();
      end
   endtask : wait_n

   initial begin
      logic ok;
      int   k;
      int   acc;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check("tx serial", {7'h00, tx_ser}, 8'h01);
      check("rx req", {7'h00, udr_if_i.rx_dma_request_n}, 8'h01);
      check("tx req", {7'h00, udr_if_i.tx_dma_request_n}, 8'h00);
      // fifo off: mode bit ignored, one char read at once
      dma_mode = 1'b1;
      push_rx(8'ha5);
      wait_n(1'b0, 1, 25);
      check("rx word", got_rx[0], 8'ha5);
      repeat (3) @(negedge clk);
      check("rx req", {7'h00, udr_if_i.rx_dma_request_n}, 8'h01);
      send(8'h3c, 100, ok);
      send(8'hc3, 100, ok);
      wait_n(1'b1, 2, 100);
      check("tx word", got_tx[0], 8'h3c);
      check("tx word", got_tx[1], 8'hc3);
      // fifo on, mode 0: single char still requested
      fifo_en = 1'b1;
      dma_mode = 1'b0;
      push_rx(8'h11);
      wait_n(1'b0, 2, 25);
      check("rx word", got_rx[1], 8'h11);
      // mode 1: below trigger waits for the timeout
      dma_mode = 1'b1;
      for (k = 0; k < 3; k++) push_rx(8'(k) + 8'h21);
      repeat (20) @(negedge clk);
      check("rx early", 8'(got_rx.size()), 8'h02);
      wait_n(1'b0, 5, 80);
      // mode 1: trigger level starts a burst that empties the fifo
      for (k = 0; k < 4; k++) push_rx(8'(k) + 8'h31);
      wait_n(1'b0, 9, 80);
      for (k = 0; k < 3; k++) begin
         check("rx word", got_rx[2+k], 8'(k) + 8'h21);
      end
      for (k = 0; k < 4; k++) begin
         check("rx word", got_rx[5+k], 8'(k) + 8'h31);
      end
      repeat (3) @(negedge clk);
      check("rx req", {7'h00, udr_if_i.rx_dma_request_n}, 8'h01);
      // mode 1 tx: stall the serial side, fill until refused
      tx_r = 1'b0;
      ok = 1'b1;
      acc = 0;
      for (k = 0; k < 24 && ok === 1'b1; k++) begin
         send(8'(k) + 8'h40, 60, ok);
         if (ok === 1'b1) acc++;
      end
      check("tx fill", 8'(acc), 8'(udr_pkg::FIFO_DEPTH));
      check("tx req", {7'h00, udr_if_i.tx_dma_request_n}, 8'h01);
      tx_r = 1'b1;
      wait_n(1'b1, 2 + acc, 800);
      for (k = 0; k < acc; k++) begin
         check("tx word", got_tx[2+k], 8'(k) + 8'h40);
      end
      repeat (10) @(negedge clk);
      check("tx req", {7'h00, udr_if_i.tx_dma_request_n}, 8'h00);
      conclude();
   end
endmodule : testbench
